// ===== logic/artx_pkg.sv
package artx_pkg;
    // Register byte offsets inside the memory window
    localparam logic [11:0] OFS_CTRL_SET  = 12'h1A0;
    localparam logic [11:0] OFS_CTRL_CLR  = 12'h1A4;
    localparam logic [11:0] OFS_PROG_PTR  = 12'h1AC;
    // Control register field positions
    localparam int BIT_RUN    = 15;
    localparam int BIT_WAKE   = 12;
    localparam int BIT_DEAD   = 11;
    localparam int BIT_ACTIVE = 10;
    localparam int EVT_HI     = 4;
    localparam int EVT_LO     = 0;
    // Pointer register fields
    localparam int PTR_ADDR_LO = 4;
    localparam int PTR_CNT_HI  = 3;
    localparam logic [3:0]  CNT_INVALID = 4'h0;
    localparam logic [4:0]  EVT_RESET   = 5'h00;
    localparam logic [31:0] PTR_RESET   = 32'h0000_0000;
    // Status codes reported after a last-output command
    typedef enum logic [4:0] {
        EVT_NO_STATUS      = 5'h00,
        EVT_TCODE_ERR      = 5'h02,
        EVT_DESCRIPTOR_RD  = 5'h05,
        EVT_DATA_READ      = 5'h06,
        EVT_MISSING_ACK    = 5'h03,
        EVT_UNDERRUN       = 5'h04,
        EVT_TIMEOUT        = 5'h0A,
        EVT_FLUSHED        = 5'h0F,
        EVT_UNKNOWN        = 5'h0E,
        ACK_COMPLETE       = 5'h11,
        ACK_PENDING        = 5'h12,
        ACK_BUSY_X         = 5'h14,
        ACK_BUSY_A         = 5'h15,
        ACK_BUSY_B         = 5'h16,
        ACK_DATA_ERROR     = 5'h1D,
        ACK_TYPE_ERROR     = 5'h1E
    } artx_evt_t;
    // Context sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_RUN   = 2'b10,
        ST_HALT  = 2'b11
    } artx_state_t;
endpackage

// ===== logic/artx_ctx_regs.sv
`timescale 1ns/10ps
module artx_ctx_regs
(
    input  wire logic                          sys_clk,
    input  wire logic                          reset_n,
    input  wire logic                          soft_reset,
    input  wire logic [11:0]                   reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [31:0]                   reg_wdata,
    output logic      [31:0]                   reg_rdata,
    output logic                               fetch_req,
    output logic      [31:0]                   fetch_addr,
    output logic      [3:0]                    fetch_blocks,
    input  wire logic                          fetch_done,
    input  wire logic                          fetch_more,
    input  wire logic                          last_output_done,
    input  wire logic [4:0]                    last_output_code,
    input  wire logic                          fatal_error,
    output logic                               ctx_active,
    output logic                               ctx_dead
);
    import artx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic        run;
    logic        wake;
    logic        dead;
    logic        active;
    logic [4:0]  evt_code;
    logic [31:0] prog_ptr;
    artx_state_t state;
    artx_state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    wire wr_set  = reg_wr && hit(reg_addr, OFS_CTRL_SET);
    wire wr_clr  = reg_wr && hit(reg_addr, OFS_CTRL_CLR);
    wire wr_ptr  = reg_wr && hit(reg_addr, OFS_PROG_PTR);
    wire rd_ctrl = hit(reg_addr, OFS_CTRL_SET)
                || hit(reg_addr, OFS_CTRL_CLR);
    wire rd_ptr  = hit(reg_addr, OFS_PROG_PTR);

    wire set_run  = wr_set && reg_wdata[BIT_RUN];
    wire clr_run  = wr_clr && reg_wdata[BIT_RUN];
    wire set_wake = wr_set && reg_wdata[BIT_WAKE];
    wire clr_wake = wr_clr && reg_wdata[BIT_WAKE];
    wire any_rst  = soft_reset;

    // Control word image; reserved positions stay zero because the word
    // starts cleared and only the named fields are filled in
    logic [31:0] ctrl_word;
    always_comb
    begin
        ctrl_word                = '0;
        ctrl_word[BIT_RUN]       = run;
        ctrl_word[BIT_WAKE]      = wake;
        ctrl_word[BIT_DEAD]      = dead;
        ctrl_word[BIT_ACTIVE]    = active;
        ctrl_word[EVT_HI:EVT_LO] = evt_code;
    end

    wire [3:0] ptr_cnt = prog_ptr[PTR_CNT_HI:0];
    wire       ptr_ok  = (ptr_cnt != CNT_INVALID);
    wire       fetching = (state == ST_FETCH);
    wire       fetch_hit = fetching && fetch_done;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (run && !clr_run && ptr_ok)
                    next_state = ST_FETCH;
            ST_FETCH:
                if (!run || clr_run)
                    next_state = ST_IDLE;
                else if (fatal_error)
                    next_state = ST_HALT;
                else if (fetch_done)
                    next_state = fetch_more ? ST_FETCH : ST_RUN;
            ST_RUN:
                if (!run || clr_run)
                    next_state = ST_IDLE;
                else if (fatal_error)
                    next_state = ST_HALT;
                else if (wake || set_wake)
                    next_state = ST_FETCH;
            ST_HALT:
                if (!run || clr_run)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
        // A soft reset also parks the next state, so fetch_req and
        // ctx_active drop in the same cycle as the state instead of
        // showing one stale cycle of a context that no longer runs
        if (any_rst)
            next_state = ST_IDLE;
    end

    wire next_active = (next_state == ST_FETCH)
                    || (next_state == ST_RUN);

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || any_rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control bits
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || any_rst)
        begin
            run    <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            if (set_run)
                run <= 1'b1;
            else if (clr_run)
                run <= 1'b0;
            active <= next_active;
        end
    end

    // A run clear always drops dead, even in a cycle that has a fatal error
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || any_rst)
            dead <= 1'b0;
        else if (clr_run)
            dead <= 1'b0;
        else if (next_state == ST_HALT && state != ST_HALT)
            dead <= 1'b1;
    end

    // A write setting wake in the fetch cycle survives, so a late kick
    // is not lost
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || any_rst)
            wake <= 1'b0;
        else if (set_wake)
            wake <= 1'b1;
        else if (fetch_hit || clr_wake)
            wake <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            evt_code <= EVT_RESET;
        else if (last_output_done)
            evt_code <= last_output_code;
    end

    ////////////////////////////////////////////////////////////////////////
    // Program pointer; writes while running are the driver's fault and
    // are still stored, the fetch address is latched at start
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            prog_ptr <= PTR_RESET;
        else if (wr_ptr)
            prog_ptr <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            reg_rdata    <= '0;
            fetch_req    <= 1'b0;
            fetch_addr   <= PTR_RESET;
            fetch_blocks <= CNT_INVALID;
            ctx_active   <= 1'b0;
            ctx_dead     <= 1'b0;
        end
        else
        begin
            if (reg_rd)
                reg_rdata <= rd_ctrl ? ctrl_word
                           : rd_ptr ? prog_ptr : '0;
            fetch_req <= (next_state == ST_FETCH);
            // Address and count are latched at start only, so a stray
            // pointer write during a run cannot move the running program
            if (state == ST_IDLE && next_state == ST_FETCH)
            begin
                fetch_addr   <= {prog_ptr[31:PTR_ADDR_LO],
                                 {PTR_ADDR_LO{1'b0}}};
                fetch_blocks <= ptr_cnt;
            end
            ctx_active <= next_active;
            ctx_dead   <= dead;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Multi-step behaviours, built up from their trigger cycles
    sequence s_start_req;
        state == ST_IDLE && run && !clr_run && ptr_ok && !soft_reset;
    endsequence

    sequence s_kick;
        state == ST_RUN && run && (wake || set_wake) && !clr_run
        && !fatal_error && !soft_reset;
    endsequence

    sequence s_fatal_hit;
        (fetching || state == ST_RUN) && run && fatal_error && !clr_run
        && !soft_reset;
    endsequence

    // The dead pin is a registered copy, so it trails the bit by a cycle
    sequence s_dead_shown;
        dead && !active ##1 ctx_dead;
    endsequence

    a_run_set_works: assert property (
        set_run && !soft_reset |=> run) else $error("run not set");
    a_run_only_reset: assert property (
        $fell(run) |-> $past(clr_run) || $past(soft_reset)
                       || $past(!reset_n))
        else $error("run cleared by hardware");
    a_wake_resumes: assert property (
        s_kick |=> fetching && fetch_req && active)
        else $error("wake did not resume fetching");
    a_wake_fetch_clr: assert property (
        fetch_hit && !set_wake && !soft_reset |=> !wake)
        else $error("wake survived fetch");

    a_dead_on_fatal: assert property (
        state == ST_RUN && run && fatal_error && !wr_clr && !soft_reset
        |=> dead) else $error("dead not set");
    a_dead_any_fatal: assert property (
        s_fatal_hit |=> s_dead_shown) else $error("dead not shown");
    a_dead_clr_run: assert property (
        clr_run |=> !dead) else $error("dead kept after run clear");

    a_active_tracks: assert property (
        active |-> run) else $error("active without run");
    a_active_state: assert property (
        active == (fetching || state == ST_RUN) && ctx_active == active)
        else $error("active out of step with state");

    a_evt_written: assert property (
        last_output_done |=> evt_code == $past(last_output_code))
        else $error("status code not written");
    a_no_fetch_zero: assert property (
        state == ST_IDLE && ptr_cnt == CNT_INVALID |=> state != ST_FETCH)
        else $error("fetch from invalid pointer");

    a_start_fetch: assert property (
        s_start_req |=> fetch_req && fetch_blocks == $past(ptr_cnt)
        && fetch_addr[31:PTR_ADDR_LO] == $past(prog_ptr[31:PTR_ADDR_LO]))
        else $error("start did not fetch from pointer");
    a_ptr_store: assert property (
        wr_ptr |=> prog_ptr == $past(reg_wdata))
        else $error("pointer write lost");
    a_clr_stops: assert property (
        clr_run |=> !run && !active && !fetch_req)
        else $error("clear did not stop context");
    a_read_same: assert property (
        reg_rd && rd_ctrl |=> reg_rdata == $past(ctrl_word))
        else $error("control read differs");
    a_rsvd_zero: assert property (
        reg_rd && rd_ctrl |=> reg_rdata[31:16] == 16'h0000
        && reg_rdata[9:5] == 5'h00) else $error("reserved nonzero");
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import artx_pkg::*;
    logic        sys_clk;
    logic        reset_n;
    logic        soft_reset;
    logic [11:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        fetch_req;
    logic [31:0] fetch_addr;
    logic [3:0]  fetch_blocks;
    logic        fetch_done;
    logic        fetch_more;
    logic        last_output_done;
    logic [4:0]  last_output_code;
    logic        fatal_error;
    logic        ctx_active;
    logic        ctx_dead;
    logic [4:0]  code;
    int          failures;
    int          num_checks;
    artx_evt_t   codes [15];

    artx_ctx_regs u_artx_ctx_regs
    (
        .sys_clk (sys_clk), .reset_n (reset_n), .soft_reset (soft_reset),
        .reg_addr (reg_addr), .reg_wr (reg_wr), .reg_rd (reg_rd),
        .reg_wdata (reg_wdata), .reg_rdata (reg_rdata),
        .fetch_req (fetch_req), .fetch_addr (fetch_addr),
        .fetch_blocks (fetch_blocks), .fetch_done (fetch_done),
        .fetch_more (fetch_more), .last_output_done (last_output_done),
        .last_output_code (last_output_code), .fatal_error (fatal_error),
        .ctx_active (ctx_active), .ctx_dead (ctx_dead)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Expected control word, built from the documented bit positions
    function automatic logic [31:0] cv(input logic r, w, d, a);
        return {16'h0000, r, 2'h0, w, d, a, 5'h00, code};
    endfunction

    // Ends three edges after the write so sequencer outputs have settled
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
    endtask

    // Bits: soft_reset, fatal_error, last_output_done, fetch_more, fetch_done
    task automatic pulse(input logic [4:0] m, input logic [4:0] c);
        @(posedge sys_clk);
        {soft_reset, fatal_error, last_output_done, fetch_more, fetch_done} <= m;
        last_output_code <= c;
        @(posedge sys_clk);
        {soft_reset, fatal_error, last_output_done, fetch_more, fetch_done}
            <= 5'h00;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic ctl(input string n, input logic r, w, d, a);
        rd(OFS_CTRL_SET);
        chk(n, cv(r, w, d, a), reg_rdata);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        {reset_n, soft_reset, reg_wr, reg_rd, fetch_done} = 5'h00;
        {fetch_more, last_output_done, fatal_error} = 3'h0;
        {reg_addr, reg_wdata, last_output_code} = 49'h0;
        codes = '{ACK_COMPLETE, ACK_PENDING, ACK_BUSY_X, ACK_BUSY_A,
            ACK_BUSY_B, ACK_DATA_ERROR, ACK_TYPE_ERROR, EVT_TCODE_ERR,
            EVT_MISSING_ACK, EVT_UNDERRUN, EVT_DESCRIPTOR_RD, EVT_DATA_READ,
            EVT_TIMEOUT, EVT_FLUSHED, EVT_UNKNOWN};
        code = EVT_RESET;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        ctl("ctrl after reset", 0, 0, 0, 0);
        rd(OFS_PROG_PTR);
        chk("ptr after reset", PTR_RESET, reg_rdata);
        chk("fetch_req idle", 32'h0, {31'h0, fetch_req});
        $display("test reset done");
        foreach (codes[i])
        begin
            pulse(5'h04, codes[i]);
            code = codes[i];
            rd(i % 2 ? OFS_CTRL_CLR : OFS_CTRL_SET);
            chk("event code", cv(0, 0, 0, 0), reg_rdata);
        end
        $display("test event codes done");
        wr(OFS_PROG_PTR, 32'h1234_5670);
        wr(OFS_CTRL_SET, 32'h0000_8000);
        chk("zero count fetch", 32'h0, {31'h0, fetch_req});
        ctl("zero count ctrl", 1, 0, 0, 0);
        wr(OFS_CTRL_CLR, 32'h0000_8000);
        wr(OFS_PROG_PTR, 32'hABCD_EF13);
        rd(OFS_PROG_PTR);
        chk("ptr readback", 32'hABCD_EF13, reg_rdata);
        wr(OFS_CTRL_SET, 32'h0000_8000);
        chk("fetch_req run", 32'h1, {31'h0, fetch_req});
        chk("fetch_addr", 32'hABCD_EF10, fetch_addr);
        chk("fetch_blocks", 32'h3, {28'h0, fetch_blocks});
        chk("active out", 32'h1, {31'h0, ctx_active});
        ctl("running ctrl", 1, 0, 0, 1);
        pulse(5'h01, 5'h00);
        chk("fetch_req after done", 32'h0, {31'h0, fetch_req});
        ctl("after fetch", 1, 0, 0, 1);
        $display("test start done");
        wr(OFS_CTRL_SET, 32'h0000_1000);
        chk("wake resumes", 32'h1, {31'h0, fetch_req});
        ctl("wake set", 1, 1, 0, 1);
        pulse(5'h03, 5'h00);
        chk("fetch chained", 32'h1, {31'h0, fetch_req});
        ctl("wake cleared", 1, 0, 0, 1);
        pulse(5'h01, 5'h00);
        chk("fetch ends", 32'h0, {31'h0, fetch_req});
        // Status-only and reserved bits must not stick through the set port
        wr(OFS_CTRL_SET, 32'hFFFF_6FFF);
        ctl("reserved ignored", 1, 0, 0, 1);
        $display("test wake done");
        pulse(5'h08, 5'h00);
        chk("dead out", 32'h1, {31'h0, ctx_dead});
        ctl("dead ctrl", 1, 0, 1, 0);
        wr(OFS_CTRL_CLR, 32'h0000_7FFF);
        ctl("clear keeps run", 1, 0, 1, 0);
        wr(OFS_CTRL_CLR, 32'h0000_8000);
        ctl("run cleared", 0, 0, 0, 0);
        chk("dead out clear", 32'h0, {31'h0, ctx_dead});
        $display("test fatal done");
        wr(12'h1A8, 32'hFFFF_FFFF);
        rd(12'h1A8);
        chk("unmapped read", 32'h0, reg_rdata);
        rd(OFS_PROG_PTR);
        chk("ptr untouched", 32'hABCD_EF13, reg_rdata);
        wr(OFS_CTRL_SET, 32'h0000_8000);
        pulse(5'h10, 5'h00);
        ctl("soft reset ctrl", 0, 0, 0, 0);
        chk("soft reset fetch", 32'h0, {31'h0, fetch_req});
        $display("test unmapped and soft reset done");
        wr(OFS_CTRL_SET, 32'h0000_8000);
        chk("refetch", 32'h1, {31'h0, fetch_req});
        pulse(5'h08, 5'h00);
        chk("fatal in fetch", 32'h0, {31'h0, fetch_req});
        chk("dead out fetch", 32'h1, {31'h0, ctx_dead});
        ctl("dead from fetch", 1, 0, 1, 0);
        $display("test fatal in fetch done");
        // Full reset in mid-run; pointer and status code return to zero
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        code = EVT_RESET;
        ctl("ctrl after mid reset", 0, 0, 0, 0);
        rd(OFS_PROG_PTR);
        chk("ptr after mid reset", PTR_RESET, reg_rdata);
        chk("dead out mid reset", 32'h0, {31'h0, ctx_dead});
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
